// ==== rtl/ebh_pkg.sv ====
/*
 * Shared constants of the event buffer header formatter: register map,
 * field positions, reset values and timing counts.
 * Assumes a 20 MHz APB clock and 32-bit APB data.
 */
package ebh_pkg;
    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [15:0] ADDR_BUF_ORG = 16'h800c;
    localparam logic [15:0] ADDR_CUSTOM_LEN = 16'h8020;
    localparam logic [15:0] ADDR_FAULT_STATUS = 16'h8104;
    localparam logic [15:0] ADDR_FP_CTRL = 16'h811c;
    localparam logic [15:0] ADDR_ACQ_CTRL = 16'h8100;
    localparam logic [15:0] ADDR_CHAN_MASK = 16'h8120;
    localparam logic [15:0] ADDR_BUF_SIZE = 16'h8140;

    // ------------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] ORG_MAX = 4'ha;
    localparam int ORG_W = 4;
    localparam int SEL_LO = 21;
    localparam int SEL_HI = 22;
    localparam logic [1:0] SEL_SOURCE = 2'b01;
    localparam logic [1:0] SEL_EXT = 2'b10;
    localparam int ACQ_RUN_BIT = 2;
    localparam int ACQ_CNT_ALL_BIT = 3;
    localparam int FAIL_BIT = 26;
    localparam int MODE_BIT = 24;
    localparam int SWTRG_BIT = 18;
    localparam int EXTTRG_BIT = 17;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [31:0] RST_CHAN_MASK = 32'hffff_ffff;

    // ------------------------------------------------------------------
    // Memory and timing
    // ------------------------------------------------------------------
    localparam int TOTAL_SAMPLES = 196608;
    localparam int GROUPS = 4;
    localparam int CH_PER_GROUP = 8;
    localparam int TAG_STEP_NS = 8;
    localparam int TAG_LATCH_NS = 16;
    localparam int CLK_NS = 50;
    // Time tag increments per APB clock, rounded down, at least one.
    localparam int TAG_INC = (CLK_NS / TAG_STEP_NS) < 1 ? 1 : (CLK_NS / TAG_STEP_NS);
    localparam int HDR_WORDS = 4;
endpackage : ebh_pkg

// ==== rtl/ebh_formatter.sv ====
/*
 * Event buffer header formatter: buffer organisation, custom length,
 * header build and sample word stream of frozen events, APB registers.
 * Assumes a single pclk domain; triggers, group requests and sample
 * reads come from logic on the same clock; the general input and the
 * lock flag are asynchronous.
 */
// Operation
// - Buffer count is two to organisation code
// - Buffer size is capacity over buffer count
// - Custom length in locations, three per two samples
// - Custom length leaves buffer count and size alone
// - Event is four header words then data
// - Word one low bits carry event size
// - Word two bit 26 flags hardware fault
// - Word two bit 24 always zero
// - Selector 00 or 11 zeroes option bits
// - Selector 01 gives trigger source bits
// - Selector 10 gives 48-bit time tag
// - Word two low byte holds group mask
// - Word three holds selectable event counter
// - Word four holds tag and sticky rollover, tag only under selector 10
// - Tag clears on start or input, 8 ns steps
// - Masked channels are omitted from data
// - Groups appear in ascending order
// - Data starts at group 0 channel 0
// - Latched tag always has zero lsb
`timescale 1ns/1ps
`default_nettype none

module ebh_formatter #(
    parameter int GROUPS = ebh_pkg::GROUPS,
    parameter int CH_PER_GROUP = ebh_pkg::CH_PER_GROUP
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic front_general_input,
    input wire logic pll_unlock,
    input wire logic trig_valid,
    input wire logic trig_accepted,
    input wire logic trig_software,
    input wire logic trig_external,
    input wire logic [GROUPS-1:0] trig_group_req,
    output logic [31:0] samp_word_req_idx,
    input wire logic [31:0] samp_word,
    output logic [31:0] ev_data,
    output logic ev_valid,
    input wire logic ev_ready,
    output logic ev_last,
    output logic busy,
    output logic [10:0] buffer_count,
    output logic [17:0] buffer_samples
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [3:0] buf_org_ff;
    logic [31:0] custom_len_ff;
    logic [31:0] fp_ctrl_ff;
    logic [31:0] acq_ctrl_ff;
    logic [31:0] chan_mask_ff;
    logic [7:0] fault_ff;
    logic apb_wr;
    logic apb_rd_hit;

    assign apb_wr = psel && penable && pwrite;
    assign pready = 1'b1;

    always_comb begin
        apb_rd_hit = 1'b1;
        case (paddr)
            ebh_pkg::ADDR_BUF_ORG: prdata = {28'h0000000, buf_org_ff};
            ebh_pkg::ADDR_CUSTOM_LEN: prdata = custom_len_ff;
            ebh_pkg::ADDR_FAULT_STATUS: prdata = {24'h000000, fault_ff};
            ebh_pkg::ADDR_FP_CTRL: prdata = fp_ctrl_ff;
            ebh_pkg::ADDR_ACQ_CTRL: prdata = acq_ctrl_ff;
            ebh_pkg::ADDR_CHAN_MASK: prdata = chan_mask_ff;
            ebh_pkg::ADDR_BUF_SIZE: prdata = {3'h0, buffer_count, buffer_samples};
            default: begin
                prdata = 32'h0000_0000;
                apb_rd_hit = 1'b0;
            end
        endcase
    end
    // Unmapped addresses answer with an error and are never written, so a
    // stray access cannot disturb the frame logic.
    assign pslverr = psel && penable && !apb_rd_hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_org_ff <= ebh_pkg::RST_ZERO[3:0];
            custom_len_ff <= ebh_pkg::RST_ZERO;
            fp_ctrl_ff <= ebh_pkg::RST_ZERO;
            acq_ctrl_ff <= ebh_pkg::RST_ZERO;
            chan_mask_ff <= ebh_pkg::RST_CHAN_MASK;
        end else if (apb_wr) begin
            case (paddr)
                ebh_pkg::ADDR_BUF_ORG: begin
                    // Codes beyond the largest organisation saturate there.
                    if (pwdata[3:0] > ebh_pkg::ORG_MAX) begin
                        buf_org_ff <= ebh_pkg::ORG_MAX;
                    end else begin
                        buf_org_ff <= pwdata[3:0];
                    end
                end
                ebh_pkg::ADDR_CUSTOM_LEN: custom_len_ff <= pwdata;
                ebh_pkg::ADDR_FP_CTRL: fp_ctrl_ff <= pwdata;
                ebh_pkg::ADDR_ACQ_CTRL: acq_ctrl_ff <= pwdata;
                ebh_pkg::ADDR_CHAN_MASK: chan_mask_ff <= pwdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Buffer organisation and event length
    // ------------------------------------------------------------------
    logic [17:0] custom_samples;
    logic [17:0] event_samples;
    logic [5:0] chan_cnt;
    logic [GROUPS-1:0] grp_mask;
    logic [27:0] data_words;
    logic [27:0] event_words;

    assign buffer_count = 11'h001 << buf_org_ff;
    // Custom length never reaches into these two values.
    assign buffer_samples = 18'(ebh_pkg::TOTAL_SAMPLES >> buf_org_ff);
    // Three locations hold two samples.
    assign custom_samples = 18'((custom_len_ff * 2) / 3);

    always_comb begin
        // Larger values are a software error; clamp to the buffer.
        if (custom_len_ff != 32'h0000_0000 && custom_samples < buffer_samples) begin
            event_samples = custom_samples;
        end else begin
            event_samples = buffer_samples;
        end
    end

    genvar g;
    generate
        for (g = 0; g < GROUPS; g++) begin : g_grp
            assign grp_mask[g] = |chan_mask_ff[g*CH_PER_GROUP +: CH_PER_GROUP];
        end
    endgenerate

    always_comb begin
        chan_cnt = 6'h00;
        for (int i = 0; i < GROUPS * CH_PER_GROUP; i++) begin
            chan_cnt = chan_cnt + 6'(chan_mask_ff[i]);
        end
    end

    // Samples are packed as 12-bit values: eight samples fill three words.
    assign data_words = 28'((32'(event_samples) * 32'(chan_cnt) * 3) / 8);
    assign event_words = data_words + 28'(ebh_pkg::HDR_WORDS);

    // ------------------------------------------------------------------
    // Time tag and event counter
    // ------------------------------------------------------------------
    logic gpi_meta_ff;
    logic gpi_sync_ff;
    logic gpi_prev_ff;
    logic run_prev_ff;
    logic [47:0] tag_ff;
    logic tag_roll_ff;
    logic [23:0] ev_cnt_ff;
    logic tag_clear;
    logic run_start;
    logic gpi_rise;
    logic [47:0] tag_sum;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpi_meta_ff <= 1'b0;
            gpi_sync_ff <= 1'b0;
            gpi_prev_ff <= 1'b0;
            run_prev_ff <= 1'b0;
        end else begin
            gpi_meta_ff <= front_general_input;
            gpi_sync_ff <= gpi_meta_ff;
            gpi_prev_ff <= gpi_sync_ff;
            run_prev_ff <= acq_ctrl_ff[ebh_pkg::ACQ_RUN_BIT];
        end
    end

    // A run start clears the tag and the event counter; the general input
    // only realigns the tag, so event numbering survives a time reset.
    assign run_start = acq_ctrl_ff[ebh_pkg::ACQ_RUN_BIT] && !run_prev_ff;
    assign gpi_rise = gpi_sync_ff && !gpi_prev_ff;
    assign tag_clear = run_start || gpi_rise;
    // Limitation: the tag moves in whole clock steps of TAG_INC counts, so
    // between two edges it only approximates the finer tag grid.
    assign tag_sum = tag_ff + 48'(ebh_pkg::TAG_INC);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tag_ff <= 48'h0000_0000_0000;
            tag_roll_ff <= 1'b0;
        end else if (tag_clear) begin
            tag_ff <= 48'h0000_0000_0000;
            tag_roll_ff <= 1'b0;
        end else begin
            // Each count is one 8 ns step of the trigger clock.
            tag_ff <= tag_sum;
            if (tag_sum[31] != tag_ff[31] && tag_ff[30:0] > tag_sum[30:0]) begin
                tag_roll_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_cnt_ff <= 24'h000000;
        end else if (run_start) begin
            // Numbering restarts with each run, not with a time tag reset.
            ev_cnt_ff <= 24'h000000;
        end else if (trig_valid && (trig_accepted || acq_ctrl_ff[ebh_pkg::ACQ_CNT_ALL_BIT])) begin
            ev_cnt_ff <= ev_cnt_ff + 24'h000001;
        end
    end

    // ------------------------------------------------------------------
    // Fault capture
    // ------------------------------------------------------------------
    logic pll_meta_ff;
    logic pll_sync_ff;

    // The lock flag comes from the clock generator, outside this domain.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_meta_ff <= 1'b0;
            pll_sync_ff <= 1'b0;
        end else begin
            pll_meta_ff <= pll_unlock;
            pll_sync_ff <= pll_meta_ff;
        end
    end

    // The flag is sticky until reset, so a brief unlock is never lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_ff <= 8'h00;
        end else if (pll_sync_ff) begin
            fault_ff[0] <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Header capture and event stream
    // ------------------------------------------------------------------
    typedef enum {EBH_IDLE, EBH_HDR, EBH_DATA} ebh_state_t;
    ebh_state_t state_ff;
    logic [31:0] hdr_ff [ebh_pkg::HDR_WORDS];
    logic [1:0] hdr_idx_ff;
    logic [27:0] data_idx_ff;
    logic [27:0] data_words_ff;
    logic [15:0] opt_bits;
    logic [47:0] tag_latched;
    logic beat;
    logic frame_start;
    logic fault_any;

    // Tag is read every second trigger clock, so its lsb stays low.
    assign tag_latched = {tag_ff[47:1], 1'b0};

    always_comb begin
        opt_bits = 16'h0000;
        case (fp_ctrl_ff[ebh_pkg::SEL_HI:ebh_pkg::SEL_LO])
            ebh_pkg::SEL_SOURCE: begin
                opt_bits[ebh_pkg::SWTRG_BIT-8] = trig_software;
                opt_bits[ebh_pkg::EXTTRG_BIT-8] = trig_external;
                opt_bits[GROUPS-1:0] = trig_group_req;
            end
            ebh_pkg::SEL_EXT: opt_bits = tag_latched[47:32];
            default: opt_bits = 16'h0000;
        endcase
    end

    assign beat = ev_valid && ev_ready;
    assign busy = state_ff != EBH_IDLE;

    // A trigger is taken only between frames; triggers during a readout are
    // held off upstream, so nothing here has to queue them.
    assign frame_start = (state_ff == EBH_IDLE) && trig_valid && trig_accepted;
    assign fault_any = fault_ff != 8'h00;

    // ------------------------------------------------------------------
    // Header capture
    // ------------------------------------------------------------------
    // All four words freeze on the trigger edge, so a register write during
    // readout cannot tear the header of the frame in flight.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_words_ff <= 28'h0000000;
            for (int i = 0; i < ebh_pkg::HDR_WORDS; i++) begin
                hdr_ff[i] <= 32'h0000_0000;
            end
        end else if (frame_start) begin
            hdr_ff[0] <= {4'ha, event_words};
            hdr_ff[1] <= {5'h00, fault_any, 1'b0, 1'b0,
                          opt_bits, 8'(grp_mask)};
            hdr_ff[2] <= {8'h00, ev_cnt_ff + 24'h000001};
            if (fp_ctrl_ff[ebh_pkg::SEL_HI:ebh_pkg::SEL_LO] == ebh_pkg::SEL_EXT) begin
                hdr_ff[3] <= tag_latched[31:0];
            end else begin
                hdr_ff[3] <= {tag_roll_ff, tag_latched[30:0]};
            end
            data_words_ff <= data_words;
        end
    end

    // ------------------------------------------------------------------
    // Frame sequencing
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= EBH_IDLE;
            hdr_idx_ff <= 2'h0;
            data_idx_ff <= 28'h0000000;
        end else begin
            case (state_ff)
                EBH_IDLE: begin
                    if (frame_start) begin
                        hdr_idx_ff <= 2'h0;
                        data_idx_ff <= 28'h0000000;
                        state_ff <= EBH_HDR;
                    end
                end
                EBH_HDR: begin
                    if (beat) begin
                        hdr_idx_ff <= hdr_idx_ff + 2'h1;
                        if (hdr_idx_ff == 2'h3) begin
                            state_ff <= (data_words_ff == 28'h0000000) ? EBH_IDLE : EBH_DATA;
                        end
                    end
                end
                EBH_DATA: begin
                    if (beat) begin
                        // Upstream memory serves words in group then channel order.
                        data_idx_ff <= data_idx_ff + 28'h0000001;
                        if (data_idx_ff == data_words_ff - 28'h0000001) begin
                            state_ff <= EBH_IDLE;
                        end
                    end
                end
                default: state_ff <= EBH_IDLE;
            endcase
        end
    end

    assign samp_word_req_idx = {4'h0, data_idx_ff};
    assign ev_valid = state_ff != EBH_IDLE;
    assign ev_data = (state_ff == EBH_HDR) ? hdr_ff[hdr_idx_ff] : samp_word;
    // The last flag is decoded from the index, so it stands exactly as long
    // as the word that it marks.
    assign ev_last = (state_ff == EBH_DATA && data_idx_ff == data_words_ff - 28'h0000001)
                     || (state_ff == EBH_HDR && hdr_idx_ff == 2'h3 && data_words_ff == 28'h0);

endmodule : ebh_formatter

`default_nettype wire

// ==== tb/ebh_asserts.sv ====
/*
 * Checker for the event formatter: buffer geometry and frame structure.
 * Assumes the single pclk domain of ebh_formatter and its port names.
 */
`timescale 1ns/1ps
`default_nettype none
module ebh_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic trig_valid,
    input wire logic trig_accepted,
    input wire logic busy,
    input wire logic [31:0] ev_data,
    input wire logic ev_valid,
    input wire logic ev_ready,
    input wire logic ev_last,
    input wire logic [10:0] buffer_count,
    input wire logic [17:0] buffer_samples
);
    logic [27:0] widx_ff;
    logic [27:0] size_ff;
    wire logic beat = ev_valid && ev_ready;
    // Word position inside the frame; the size word is kept for the final beat.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            widx_ff <= 28'h0;
            size_ff <= 28'h0;
        end else if (beat) begin
            widx_ff <= ev_last ? 28'h0 : widx_ff + 28'h1;
            if (widx_ff == 28'h0) size_ff <= ev_data[27:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_GEOMETRY: assert property (buffer_count <= 11'h400 && $countones(buffer_count) == 1
        && 32'(buffer_count) * 32'(buffer_samples) == 32'd196608)
        else $error("buffer geometry wrong");
    AST_RESIZE: assert property (psel && penable && pwrite && paddr == ebh_pkg::ADDR_CUSTOM_LEN
        |=> $stable(buffer_count) && $stable(buffer_samples))
        else $error("custom length moved buffer geometry");
    AST_START: assert property (trig_valid && trig_accepted && !busy && !ev_valid
        |=> ev_valid && widx_ff == 28'h0)
        else $error("frame did not start after trigger");
    AST_HOLD: assert property (ev_valid && !ev_ready
        |=> ev_valid && $stable(ev_data) && $stable(ev_last))
        else $error("stalled word changed");
    AST_LAST: assert property (beat && ev_last |-> widx_ff >= 28'h3)
        else $error("frame shorter than header");
    AST_SIZE: assert property (beat && ev_last |-> widx_ff + 28'h1 == size_ff)
        else $error("size word disagrees with frame");
    AST_MODE: assert property (ev_valid && widx_ff == 28'h1 |-> !ev_data[24])
        else $error("format bit set");
    AST_TAG_LSB: assert property (ev_valid && widx_ff == 28'h3 |-> !ev_data[0])
        else $error("time tag lsb set");
endmodule : ebh_asserts
bind ebh_formatter ebh_asserts u_ebh_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .trig_valid(trig_valid),
    .trig_accepted(trig_accepted), .busy(busy), .ev_data(ev_data), .ev_valid(ev_valid),
    .ev_ready(ev_ready), .ev_last(ev_last), .buffer_count(buffer_count),
    .buffer_samples(buffer_samples));
`default_nettype wire

// ==== tb/ebh_host_model.sv ====
/*
 * Host reader model: takes stream words and serves sample words.
 * Assumes the testbench picks prompt or slow pacing between frames.
 */
`timescale 1ns/1ps
`default_nettype none
module ebh_host_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic [31:0] samp_word_req_idx,
    output logic [31:0] samp_word,
    output logic ev_ready
);
    logic [1:0] pace_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pace_ff <= 2'h0;
        else pace_ff <= pace_ff + 2'h1;
    end
    // Slow pacing takes one word in four, so stalled words must be held.
    assign ev_ready = !slow || pace_ff == 2'h3;
    assign samp_word = samp_word_req_idx ^ 32'h5a5a_0000;
endmodule : ebh_host_model
`default_nettype wire

// ==== tb/event_buffer_header_formatter_tb_top.sv ====
/*
 * Testbench: APB register checks, buffer geometry and framed events.
 * Assumes a zero-wait APB slave and the host model on the stream side.
 */
`timescale 1ns/1ps
`default_nettype none
module event_buffer_header_formatter_tb_top;
    logic pclk, presetn, psel, penable, pwrite, fgi, pll, tv, ta, tsw, tex, slow;
    logic pready, pslverr, ev_valid, ev_ready, ev_last, busy, err;
    logic [3:0] tgr;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, sidx, sword, ev_data, lfsr, rd;
    logic [10:0] bcount;
    logic [17:0] bsamp;
    logic [64:0] q[$];
    logic [64:0] ent;
    logic [31:0] masks[5] = '{32'h0000_00ff, 32'hff00_ff00, 32'hffff_ffff, 32'h1, 32'hff};
    int lens[5] = '{12, 12, 3, 12, 0};
    int compares, miscompares, cycles, cnt, k, m;

    ebh_formatter dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .front_general_input(fgi), .pll_unlock(pll), .trig_valid(tv),
        .trig_accepted(ta), .trig_software(tsw), .trig_external(tex), .trig_group_req(tgr),
        .samp_word_req_idx(sidx), .samp_word(sword), .ev_data(ev_data), .ev_valid(ev_valid),
        .ev_ready(ev_ready), .ev_last(ev_last), .busy(busy), .buffer_count(bcount),
        .buffer_samples(bsamp));
    ebh_host_model host (.pclk(pclk), .presetn(presetn), .slow(slow),
        .samp_word_req_idx(sidx), .samp_word(sword), .ev_ready(ev_ready));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    function automatic logic [31:0] nxt_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt_rand

    task automatic conclude();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("Error t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (!pready) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic trig(input logic acc);
        int s, dw;
        logic [7:0] gm;
        logic [15:0] opt;
        @(posedge pclk);
        fgi <= 1'b1;
        repeat (2) @(posedge pclk);
        fgi <= 1'b0;
        repeat (4) @(posedge pclk);
        lfsr = nxt_rand(lfsr);
        tv <= 1'b1;
        ta <= acc;
        tsw <= lfsr[0];
        tex <= lfsr[1];
        tgr <= lfsr[5:2];
        @(posedge pclk);
        tv <= 1'b0;
        if (acc || k >= 3) cnt++;
        if (acc) begin
            s = (lens[k] == 0) ? 192 : lens[k] * 2 / 3;
            dw = s * $countones(masks[k]) * 3 / 8;
            gm = 8'h0;
            for (int g = 0; g < 4; g++) gm[g] = |masks[k][8*g +: 8];
            opt = (k % 4 == 1) ? {5'h0, lfsr[0], lfsr[1], 5'h0, lfsr[5:2]} : 16'h0;
            q.push_back({1'b0, 32'hffff_ffff, 4'ha, 28'(4 + dw)});
            q.push_back({1'b0, 32'h05ff_ffff, 5'h0, k == 4, 2'h0, opt, gm});
            q.push_back({1'b0, 32'h00ff_ffff, 32'(cnt)});
            q.push_back({1'b0, 32'h7fff_ff01, 32'h0});
            for (int i = 0; i < dw; i++) q.push_back({i == dw - 1, 32'hffff_ffff, 32'(i) ^ 32'h5a5a_0000});
            while (q.size() != 0) @(posedge pclk);
        end
    endtask : trig

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end else if (presetn && ev_valid && ev_ready) begin
            if (q.size() == 0) begin
                miscompares++;
                $display("Error t=%0t got=%h exp=%h", $time, ev_data, 32'h0);
            end else begin
                ent = q.pop_front();
                chk(ev_data & ent[63:32], ent[31:0] & ent[63:32]);
                chk({31'h0, ev_last}, {31'h0, ent[64]});
            end
        end
    end

    initial begin
        {psel, penable, pwrite, fgi, pll, tv, ta, tsw, tex, slow, presetn} = '0;
        tgr = '0;
        paddr = '0;
        pwdata = '0;
        lfsr = 32'h11b1decd;
        {compares, miscompares, cycles, cnt} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ebh_pkg::ADDR_CUSTOM_LEN, 32'h0);
        chk(rd, ebh_pkg::RST_ZERO);
        apb(1'b0, ebh_pkg::ADDR_CHAN_MASK, 32'h0);
        chk(rd, ebh_pkg::RST_CHAN_MASK);
        apb(1'b1, 16'h8004, 32'h1);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, ebh_pkg::ADDR_FAULT_STATUS, 32'hffff_ffff);
        apb(1'b0, ebh_pkg::ADDR_FAULT_STATUS, 32'h0);
        chk(rd, 32'h0);
        for (k = 0; k < 12; k++) begin
            apb(1'b1, ebh_pkg::ADDR_BUF_ORG, 32'(k));
            m = (k > 10) ? 10 : k;
            apb(1'b0, ebh_pkg::ADDR_BUF_ORG, 32'h0);
            chk(rd, 32'(m));
            chk(32'(bcount), 32'h1 << m);
            chk(32'(bsamp), 32'd196608 >> m);
        end
        apb(1'b1, ebh_pkg::ADDR_CUSTOM_LEN, 32'h3);
        chk({bcount, 3'h0, bsamp}, {11'h400, 3'h0, 18'd192});
        for (k = 0; k < 5; k++) begin
            apb(1'b1, ebh_pkg::ADDR_FP_CTRL, 32'(k % 4) << 21);
            apb(1'b1, ebh_pkg::ADDR_CHAN_MASK, masks[k]);
            // Length changes only while stopped; each restart zeroes the count.
            apb(1'b1, ebh_pkg::ADDR_ACQ_CTRL, 32'h0);
            apb(1'b1, ebh_pkg::ADDR_CUSTOM_LEN, 32'(lens[k]));
            apb(1'b1, ebh_pkg::ADDR_ACQ_CTRL, (k >= 3) ? 32'hc : 32'h4);
            cnt = 0;
            if (k == 4) begin
                pll <= 1'b1;
                @(posedge pclk);
                pll <= 1'b0;
            end
            slow <= k[0];
            if (k > 0) trig(1'b0);
            trig(1'b1);
        end
        apb(1'b0, ebh_pkg::ADDR_FAULT_STATUS, 32'h0);
        chk(rd & 32'h1, 32'h1);
        conclude();
    end
endmodule : event_buffer_header_formatter_tb_top
`default_nettype wire
